// ===== common/sdr_latency_defs.svh
`ifndef SDR_LATENCY_DEFS_SVH
`define SDR_LATENCY_DEFS_SVH

`define TBL_PARAM_ID     8'h90
`define TBL_PARAM_LEN    8'h56
`define TBL_NUM_ROWS     8'h06
`define TBL_ROW_LEN      8'h0e
`define TBL_LAST_OFFSET  7'h57
`define TBL_ROW1_BASE    7'h04
`define TBL_UNSUPPORTED  8'hff
`define TBL_NUM_BANDS    3'h5
`define TBL_NUM_CMDS     3'h6
`define TBL_CODE_W       2

`endif

// ===== common/sdr_latency_pkg.sv
package sdr_latency_pkg;
    // read command columns in table order
    typedef enum logic [2:0] {
        CMD_READ      = 3'h0,
        CMD_FAST      = 3'h1,
        CMD_DUAL_OUT  = 3'h2,
        CMD_QUAD_OUT  = 3'h3,
        CMD_DUAL_IO   = 3'h4,
        CMD_QUAD_IO   = 3'h5
    } read_cmd_t;

    // frequency bands, each one row after the header row
    typedef enum logic [2:0] {
        BAND_50M   = 3'h0,
        BAND_80M   = 3'h1,
        BAND_90M   = 3'h2,
        BAND_104M  = 3'h3,
        BAND_133M  = 3'h4
    } band_t;
endpackage

// ===== rtl/sdr_latency_table.sv
`timescale 1ns/1ps
`include "sdr_latency_defs.svh"

module sdr_latency_table
    import sdr_latency_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // byte read port of the parameter block
    input  wire logic        rd_en_in,
    input  wire logic [6:0]  rd_addr_in,
    output logic      [7:0]  rd_data_out,
    output logic             rd_valid_out,
    // latency lookup by band and command
    input  wire logic        lookup_en_in,
    input  wire logic [2:0]  band_sel_in,
    input  wire logic [2:0]  cmd_sel_in,
    output logic      [7:0]  freq_limit_out,
    output logic      [1:0]  latency_code_out,
    output logic      [7:0]  mode_cycles_out,
    output logic      [7:0]  latency_cycles_out,
    output logic             supported_out,
    output logic             lookup_valid_out
);

    // table contents are constant, so a case function maps to plain gates
    function automatic logic [7:0] tbl_byte(input logic [6:0] a);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            7'h00: d = `TBL_PARAM_ID;
            7'h01: d = `TBL_PARAM_LEN;
            7'h02: d = `TBL_NUM_ROWS;
            7'h03: d = `TBL_ROW_LEN;
            7'h04: d = 8'h46;
            7'h05: d = 8'h43;
            7'h06: d = 8'h03;
            7'h07: d = 8'h13;
            7'h08: d = 8'h0b;
            7'h09: d = 8'h0c;
            7'h0a: d = 8'h3b;
            7'h0b: d = 8'h3c;
            7'h0c: d = 8'h6b;
            7'h0d: d = 8'h6c;
            7'h0e: d = 8'hbb;
            7'h0f: d = 8'hbc;
            7'h10: d = 8'heb;
            7'h11: d = 8'hec;
            7'h12: d = 8'h32;
            7'h13: d = 8'h03;
            7'h1d: d = 8'h04;
            7'h1e: d = 8'h02;
            7'h1f: d = 8'h01;
            7'h20: d = 8'h50;
            7'h21: d = 8'h00;
            7'h22: d = `TBL_UNSUPPORTED;
            7'h23: d = `TBL_UNSUPPORTED;
            7'h25: d = 8'h08;
            7'h27: d = 8'h08;
            7'h29: d = 8'h08;
            7'h2b: d = 8'h04;
            7'h2c: d = 8'h02;
            7'h2d: d = 8'h04;
            7'h2e: d = 8'h5a;
            7'h2f: d = 8'h01;
            7'h30: d = `TBL_UNSUPPORTED;
            7'h31: d = `TBL_UNSUPPORTED;
            7'h33: d = 8'h08;
            7'h35: d = 8'h08;
            7'h37: d = 8'h08;
            7'h39: d = 8'h05;
            7'h3a: d = 8'h02;
            7'h3b: d = 8'h04;
            7'h3c: d = 8'h68;
            7'h3d: d = 8'h02;
            7'h3e: d = `TBL_UNSUPPORTED;
            7'h3f: d = `TBL_UNSUPPORTED;
            7'h41: d = 8'h08;
            7'h43: d = 8'h08;
            7'h45: d = 8'h08;
            7'h47: d = 8'h06;
            7'h48: d = 8'h02;
            7'h49: d = 8'h05;
            7'h4a: d = 8'h85;
            7'h4b: d = 8'h02;
            7'h4f: d = 8'h08;
            default: begin
                // fast read in row 6 stays 0+8; the rest of row 6 after its two header bytes is all ones
                if (a >= 7'h4c && a <= `TBL_LAST_OFFSET && a != 7'h4e) begin
                    d = `TBL_UNSUPPORTED;
                end
            end
        endcase
        return d;
    endfunction

    // row base: header row first, then one row per band
    wire logic       band_ok  = (band_sel_in < `TBL_NUM_BANDS) && (cmd_sel_in < `TBL_NUM_CMDS);
    wire logic [6:0] row_base = 7'(`TBL_ROW1_BASE + (7'(band_sel_in) + 7'h01) * 7'(`TBL_ROW_LEN));
    wire logic [6:0] mode_adr = 7'(row_base + 7'h02 + {3'h0, cmd_sel_in, 1'b0});
    wire logic [7:0] mode_val = tbl_byte(mode_adr);
    wire logic [7:0] lat_val  = tbl_byte(7'(mode_adr + 7'h01));
    wire logic [7:0] rd_val   = (rd_addr_in <= `TBL_LAST_OFFSET) ? tbl_byte(rd_addr_in) : 8'h00;
    // row header bytes get their own wires: a function result cannot be part-selected in place
    wire logic [7:0] freq_val = tbl_byte(row_base);
    wire logic [7:0] code_val = tbl_byte(7'(row_base + 7'h01));
    // an all-ones byte in either column withdraws the command for that band
    wire logic       cmd_ok   = band_ok && (mode_val != `TBL_UNSUPPORTED) && (lat_val != `TBL_UNSUPPORTED);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rd_data_out  <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_en_in;
            if (rd_en_in) begin
                rd_data_out <= rd_val;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            freq_limit_out     <= 8'h00;
            latency_code_out   <= 2'h0;
            mode_cycles_out    <= 8'h00;
            latency_cycles_out <= 8'h00;
            supported_out      <= 1'b0;
            lookup_valid_out   <= 1'b0;
        end else begin
            lookup_valid_out <= lookup_en_in;
            if (lookup_en_in) begin
                freq_limit_out     <= band_ok ? freq_val : 8'h00;
                latency_code_out   <= band_ok ? code_val[`TBL_CODE_W-1:0] : 2'h0;
                mode_cycles_out    <= band_ok ? mode_val : `TBL_UNSUPPORTED;
                latency_cycles_out <= band_ok ? lat_val : `TBL_UNSUPPORTED;
                supported_out      <= cmd_ok;
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // one lookup request for a fixed band and command column
    sequence lk(logic [2:0] b, logic [2:0] c);
        lookup_en_in && band_sel_in == b && cmd_sel_in == c;
    endsequence

    // any valid column of one band, for checks on the row's own bytes
    sequence lk_row(logic [2:0] b);
        lookup_en_in && band_sel_in == b && cmd_sel_in < 3'h6;
    endsequence

    sequence rd_at(logic [6:0] a);
        rd_en_in && rd_addr_in == a;
    endsequence

    AST_ID_BYTE: assert property (rd_at(7'h00) |=> rd_valid_out && rd_data_out == 8'h90)
        else $error("parameter id byte wrong");
    AST_PARAM_LEN: assert property (rd_at(7'h01) |=> rd_data_out == 8'h56)
        else $error("parameter length byte wrong");
    AST_ROW_LEN: assert property (rd_at(7'h03) ##1 rd_at(7'h02)
        |=> $past(rd_data_out) == 8'h0e && rd_data_out == 8'h06)
        else $error("row count or length wrong");
    AST_PAST_END: assert property (rd_en_in && rd_addr_in > 7'h57 |=> rd_data_out == 8'h00)
        else $error("offset past the block not zero");
    AST_RD_PULSE: assert property (!rd_en_in |=> !rd_valid_out && $stable(rd_data_out))
        else $error("read valid or byte moved without a request");

    AST_LK_PULSE: assert property (lookup_en_in |=> lookup_valid_out)
        else $error("lookup answer missing");
    AST_LK_HOLD: assert property (!lookup_en_in |=> !lookup_valid_out && $stable(mode_cycles_out)
        && $stable(latency_cycles_out) && $stable(supported_out))
        else $error("lookup answer moved without a request");
    AST_BAD_SEL: assert property (lookup_en_in && (band_sel_in > 3'h4 || cmd_sel_in > 3'h5) |=> !supported_out
        && mode_cycles_out == 8'hff && latency_cycles_out == 8'hff && freq_limit_out == 8'h00)
        else $error("invalid selection not refused");
    AST_FF_MEANS_OFF: assert property (lookup_valid_out
        && (mode_cycles_out == 8'hff || latency_cycles_out == 8'hff) |-> !supported_out)
        else $error("all-ones entry reported as supported");

    AST_80M_ROW: assert property (lk_row(BAND_80M) |=> freq_limit_out == 8'h50 && latency_code_out == 2'h0)
        else $error("80 MHz row header wrong");
    AST_80M_READ: assert property (lk(3'h1, 3'h0) |=> latency_code_out == 2'h0 && !supported_out)
        else $error("80 MHz band code or read support wrong");
    AST_80M_FAST: assert property (lk(BAND_80M, CMD_FAST) |=> supported_out
        && mode_cycles_out == 8'h00 && latency_cycles_out == 8'h08)
        else $error("80 MHz fast read entry wrong");
    AST_80M_DIO: assert property (lk(3'h1, 3'h4) |=> mode_cycles_out == 8'h00 && latency_cycles_out == 8'h04)
        else $error("80 MHz dual io entry wrong");
    AST_80M_QIO: assert property (lk(BAND_80M, CMD_QUAD_IO) |=> supported_out
        && mode_cycles_out == 8'h02 && latency_cycles_out == 8'h04)
        else $error("80 MHz quad io entry wrong");

    AST_90M_ROW: assert property (lk_row(BAND_90M) |=> freq_limit_out == 8'h5a && latency_code_out == 2'h1)
        else $error("90 MHz row header wrong");
    AST_90M_READ: assert property (lk(BAND_90M, CMD_READ) |=> !supported_out
        && mode_cycles_out == 8'hff && latency_cycles_out == 8'hff)
        else $error("90 MHz normal read not withdrawn");
    AST_90M_FAST: assert property (lk(BAND_90M, CMD_FAST) |=> supported_out
        && mode_cycles_out == 8'h00 && latency_cycles_out == 8'h08)
        else $error("90 MHz fast read entry wrong");
    AST_90M_DIO: assert property (lk(BAND_90M, CMD_DUAL_IO) |=> supported_out
        && mode_cycles_out == 8'h00 && latency_cycles_out == 8'h05)
        else $error("90 MHz dual io entry wrong");
    AST_90M_QIO: assert property (lk(3'h2, 3'h5) |=> latency_code_out == 2'h1 && mode_cycles_out == 8'h02
        && latency_cycles_out == 8'h04 && supported_out)
        else $error("90 MHz quad io entry wrong");

    AST_104M_ROW: assert property (lk_row(BAND_104M) |=> freq_limit_out == 8'h68 && latency_code_out == 2'h2)
        else $error("104 MHz row header wrong");
    AST_104M_READ: assert property (lk(BAND_104M, CMD_READ) |=> !supported_out
        && mode_cycles_out == 8'hff && latency_cycles_out == 8'hff)
        else $error("104 MHz normal read not withdrawn");
    AST_104M_QOUT: assert property (lk(BAND_104M, CMD_QUAD_OUT) |=> supported_out
        && mode_cycles_out == 8'h00 && latency_cycles_out == 8'h08)
        else $error("104 MHz quad out entry wrong");
    AST_104M_DIO: assert property (lk(3'h3, 3'h4) |=> latency_code_out == 2'h2 && latency_cycles_out == 8'h06
        && supported_out)
        else $error("104 MHz dual io entry wrong");
    AST_104M_QIO: assert property (lk(BAND_104M, CMD_QUAD_IO) |=> supported_out
        && mode_cycles_out == 8'h02 && latency_cycles_out == 8'h05)
        else $error("104 MHz quad io entry wrong");

    AST_133M_ROW: assert property (lk_row(BAND_133M) |=> freq_limit_out == 8'h85 && latency_code_out == 2'h2)
        else $error("133 MHz row header wrong");
    AST_133M_FAST: assert property (lk(BAND_133M, CMD_FAST) |=> supported_out
        && mode_cycles_out == 8'h00 && latency_cycles_out == 8'h08)
        else $error("133 MHz fast read entry wrong");
    // the answer belongs to the column asked one edge earlier, hence the past value
    AST_133M_ONLY_FAST: assert property (lk_row(BAND_133M)
        |=> supported_out == ($past(cmd_sel_in) == 3'h1))
        else $error("133 MHz support wrong");

endmodule // sdr_latency_table

// ===== verif/lat_host_model.sv
`timescale 1ns/1ps

module lat_host_model (
    // clock
    input  wire logic       clk_in,
    // requests from the bench
    input  wire logic       req_in,
    input  wire logic [2:0] band_in,
    input  wire logic [2:0] cmd_in,
    // answer of the table
    input  wire logic       valid_in,
    input  wire logic [7:0] mode_in,
    input  wire logic [7:0] lat_in,
    input  wire logic       sup_in,
    // lookup port and programmed dummy count
    output logic            en_out,
    output logic      [2:0] band_out,
    output logic      [2:0] cmd_out,
    output logic      [7:0] dummy_out
);
    assign en_out   = req_in;
    assign band_out = band_in;
    assign cmd_out  = cmd_in;
    // dummy is the mode and latency pair summed; ff keeps the host off an unusable command
    always_ff @(posedge clk_in) begin
        if (valid_in) begin
            dummy_out <= sup_in ? mode_in + lat_in : 8'hff;
        end
    end
endmodule // lat_host_model

// ===== verif/sdr_latency_table_tb.sv
`timescale 1ns/1ps

module sdr_latency_table_tb;
    import sdr_latency_pkg::*;
    localparam logic [7:0] HDR [18]    = '{8'h90, 8'h56, 8'h06, 8'h0e, 8'h46, 8'h43, 8'h03, 8'h13, 8'h0b,
        8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec};
    localparam logic [7:0] FREQ [5]    = '{8'h32, 8'h50, 8'h5a, 8'h68, 8'h85};
    localparam logic [1:0] CODE [5]    = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h2};
    localparam logic [7:0] LAT [5][6]  = '{'{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h01},
        '{8'hff, 8'h08, 8'h08, 8'h08, 8'h04, 8'h04}, '{8'hff, 8'h08, 8'h08, 8'h08, 8'h05, 8'h04},
        '{8'hff, 8'h08, 8'h08, 8'h08, 8'h06, 8'h05}, '{8'hff, 8'h08, 8'hff, 8'hff, 8'hff, 8'hff}};
    logic       clk_in = 1'b0;
    logic       rstn = 1'b0;
    logic       rd_en = 1'b0;
    logic [6:0] rd_addr = 7'h00;
    logic       req = 1'b0;
    logic [2:0] band = 3'h0;
    logic [2:0] cmd = 3'h0;
    logic [7:0] rd_data, freq, mode, lat, dummy;
    logic [2:0] lk_band, lk_cmd;
    logic [1:0] code;
    logic       rd_valid, lk_en, sup, lk_valid;
    int         fails = 0;
    int         check_count = 0;
    int         cycles = 0;

    always #4 clk_in = ~clk_in;

    sdr_latency_table dut (.clk_in(clk_in), .rstn_in(rstn), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid), .lookup_en_in(lk_en), .band_sel_in(lk_band),
        .cmd_sel_in(lk_cmd), .freq_limit_out(freq), .latency_code_out(code), .mode_cycles_out(mode),
        .latency_cycles_out(lat), .supported_out(sup), .lookup_valid_out(lk_valid));
    lat_host_model host (.clk_in(clk_in), .req_in(req), .band_in(band), .cmd_in(cmd), .valid_in(lk_valid),
        .mode_in(mode), .lat_in(lat), .sup_in(sup), .en_out(lk_en), .band_out(lk_band), .cmd_out(lk_cmd),
        .dummy_out(dummy));

    task automatic complete_run();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] exp_byte(input int a);
        int r;
        int k;
        if (a > 8'h57) return 8'h00;
        if (a < 18) return HDR[a];
        r = (a - 18) / 14;
        k = (a - 18) % 14;
        if (k < 2) return k == 0 ? FREQ[r] : {6'h00, CODE[r]};
        if (k % 2 == 1 || LAT[r][k / 2 - 1] == 8'hff) return LAT[r][k / 2 - 1];
        return k == 12 ? 8'h02 : 8'h00;
    endfunction

    // reads run back to back, one new offset every cycle; 03h then 02h first walks the row-size pair
    task automatic test_bytes();
        rd_en = 1'b1;
        rd_addr = 7'h03;
        @(negedge clk_in);
        cmp(rd_data, 8'h0e, "row length");
        rd_addr = 7'h02;
        @(negedge clk_in);
        cmp(rd_data, 8'h06, "row count");
        for (int a = 0; a <= 8'h58; a++) begin
            rd_addr = a[6:0];
            @(negedge clk_in);
            cmp(rd_valid, 8'h01, "read valid");
            cmp(rd_data, exp_byte(a), "table byte");
        end
        rd_addr = 7'h00;
        @(negedge clk_in);
        rd_en = 1'b0;
        @(negedge clk_in);
        cmp(rd_valid, 8'h00, "valid pulse");
        cmp(rd_data, 8'h90, "held byte");
        $display("test bytes done");
    endtask

    task automatic lookup(input int b, input int c);
        logic       ok;
        logic [7:0] m;
        logic [7:0] l;
        ok = b < 5 && c < 6;
        l = ok ? LAT[b][c] : 8'hff;
        m = l == 8'hff ? 8'hff : (c == 5 ? 8'h02 : 8'h00);
        req = 1'b1;
        band = b[2:0];
        cmd = c[2:0];
        @(negedge clk_in);
        req = 1'b0;
        cmp(lk_valid, 8'h01, "lookup valid");
        cmp(freq, ok ? FREQ[b] : 8'h00, "freq");
        cmp(code, ok ? CODE[b] : 2'h0, "code");
        cmp(mode, m, "mode");
        cmp(lat, l, "latency");
        cmp(sup, l != 8'hff, "supported");
        @(negedge clk_in);
        cmp(lk_valid, 8'h00, "lookup pulse");
        cmp(dummy, l == 8'hff ? 8'hff : m + l, "host dummy");
    endtask

    task automatic test_lookups();
        for (int b = 0; b < 5; b++) for (int c = 0; c < 6; c++) lookup(b, c);
        lookup(5, 1);
        lookup(2, 6);
        $display("test lookups done");
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        repeat (8) @(negedge clk_in);
        rstn = 1'b1;
        @(negedge clk_in);
        cmp(rd_valid | lk_valid | sup, 8'h00, "reset outputs");
        test_bytes();
        test_lookups();
        complete_run();
    end
endmodule // sdr_latency_table_tb
